/* File: src/haptic_wave_pkg.sv */
// Package for the custom per-period haptic waveform drive block.
// Assumes one 50 MHz clock domain; all settings arrive as plain ports.
package haptic_wave_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int AMP_W = 8;
    localparam int PER_W = 20;
    localparam int COEF_W = 8;
    localparam int PT_W = 4;
    localparam logic [PT_W-1:0] PT_LAST = 4'hf;
    localparam logic [PT_W-1:0] PT_ZERO = 4'h0;
    localparam logic [PT_W-1:0] PT_PEAK = 4'h4;
    localparam logic [PT_W-1:0] PT_MID = 4'h8;
    localparam logic [PT_W-1:0] PT_HALF_MASK = 4'h7;
    localparam logic [PT_W-1:0] PT_FOLD = 4'h8;
    localparam int PT_SHIFT = 4;
    // Coefficients are fractions of full scale in 1/256 steps (~37.9/70.3/92.2 %)
    localparam logic [COEF_W-1:0] COEF1_RST = 8'h61;
    localparam logic [COEF_W-1:0] COEF2_RST = 8'hb4;
    localparam logic [COEF_W-1:0] COEF3_RST = 8'hec;
    localparam logic [COEF_W-1:0] COEF_FULL = 8'hff;
    localparam logic [COEF_W-1:0] COEF_NONE = 8'h00;
    // Undervoltage: code 0..3 -> 2.7..3.0 V, 100 mV steps
    localparam logic [1:0] UV_RST = 2'h1;
    // Slew trim: code 0..3 -> 25..100 mV/ns, reset at fastest
    localparam logic [1:0] SLEW_RST = 2'h3;
    localparam logic [PER_W-1:0] PER_RST = 20'h3d090;

    typedef struct packed {
        logic [COEF_W-1:0] p1;
        logic [COEF_W-1:0] p2;
        logic [COEF_W-1:0] p3;
    } coef_s;

    typedef struct packed {
        logic [1:0] uv_sel;
        logic [1:0] ls_slew;
        logic [1:0] hs_slew;
        logic [1:0] cap_trim;
        logic [1:0] res_trim;
        logic narrow_band;
    } trim_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_DRIVE = 3'b010,
        ST_FAULT = 3'b100
    } drv_st_e;
endpackage

/* File: src/haptic_custom_wave_drive.sv */
// Custom per-period waveform generator with fault handling and half-period flag.
// Assumes synchronous inputs, host programs setup bits before drive starts.
// Functional notes
// - Sixteen points, zero to four mirrored
// - Point zero empty, four full, coefficients between
// - Coefficients reset near sine values
// - Shape per period, envelope from amplitude
// - Amplitude and period accepted while custom
// - Embedded mode clears faults entering inactive
// - Fault stops drive, loop off, inactive
// - Half-period flag toggles each half period
// - Undervoltage select defaults 2.8 V
// - Slew trims default fastest 100 mV/ns
`timescale 1ns/1ns
module haptic_custom_wave_drive (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic custom_shape_select,
    input wire logic embedded_mode,
    input wire logic play_req,
    input wire logic play_stop,
    input wire logic fault_detect,
    input wire logic fault_clear,
    input wire logic [haptic_wave_pkg::AMP_W-1:0] direct_amplitude_value,
    input wire logic [haptic_wave_pkg::PER_W-1:0] period_cycles,
    input wire logic coef_wr,
    input wire haptic_wave_pkg::coef_s coef_wdata,
    input wire logic trim_wr,
    input wire haptic_wave_pkg::trim_s trim_wdata,
    output logic [haptic_wave_pkg::AMP_W-1:0] drive_mag,
    output logic drive_neg,
    output logic drive_active,
    output logic current_loop_on,
    output logic fault_flag,
    output logic half_period_flag,
    output logic [haptic_wave_pkg::PT_W-1:0] point_index,
    output haptic_wave_pkg::coef_s coef_rd,
    output haptic_wave_pkg::trim_s trim_rd
);
    import haptic_wave_pkg::*;

    // Scale amplitude by a coefficient fraction
    function automatic logic [AMP_W-1:0] scale(input logic [AMP_W-1:0] a,
                                               input logic [COEF_W-1:0] c);
        logic [AMP_W+COEF_W-1:0] p;
        p = a * c;
        scale = p[AMP_W+COEF_W-1:COEF_W];
    endfunction

    drv_st_e st_ff, nxt_st;
    coef_s coef_ff, nxt_coef, act_coef_ff, nxt_act_coef;
    trim_s trim_ff, nxt_trim;
    logic [PER_W-1:0] step_ff, nxt_step, tick_ff, nxt_tick;
    logic [PT_W-1:0] pt_ff, nxt_pt;
    logic [AMP_W-1:0] mag_ff, nxt_mag;
    logic neg_ff, nxt_neg, pol_ff, nxt_pol, fault_ff, nxt_fault;
    logic act_ff, nxt_act, loop_ff, nxt_loop;
    logic [PT_W-1:0] fold;
    logic [COEF_W-1:0] cur_coef;
    logic step_done;

    // Tick runs step..1 so a point lasts exactly period/16 cycles; step 0 still gives one cycle
    assign step_done = (tick_ff <= PER_W'(1));

    always_comb begin
        nxt_st = st_ff;
        nxt_fault = fault_ff;
        nxt_coef = coef_ff;
        nxt_trim = trim_ff;
        if (trim_wr) begin
            nxt_trim = trim_wdata;
        end
        if (coef_wr) begin
            nxt_coef = coef_wdata;
        end
        if (fault_clear) begin
            nxt_fault = 1'b0;
        end
        // Set wins over clear
        if (fault_detect) begin
            nxt_fault = 1'b1;
        end
        unique case (st_ff)
            ST_IDLE: begin
                if (play_req && !fault_detect && !fault_ff) begin
                    nxt_st = ST_DRIVE;
                end
            end
            ST_DRIVE: begin
                if (fault_detect) begin
                    nxt_st = ST_FAULT;
                end else if (play_stop) begin
                    nxt_st = ST_IDLE;
                    if (embedded_mode) begin
                        nxt_fault = 1'b0;
                    end
                end
            end
            ST_FAULT: begin
                nxt_st = ST_IDLE;
                if (embedded_mode && !fault_detect) begin
                    nxt_fault = 1'b0;
                end
            end
        endcase
        nxt_act = (nxt_st == ST_DRIVE);
        nxt_loop = (nxt_st == ST_DRIVE);
    end

    always_comb begin
        nxt_tick = tick_ff;
        nxt_pt = pt_ff;
        nxt_step = step_ff;
        nxt_act_coef = act_coef_ff;
        nxt_pol = pol_ff;
        if (st_ff != ST_DRIVE) begin
            nxt_pt = PT_ZERO;
            nxt_step = PER_W'(period_cycles >> PT_SHIFT);
            nxt_tick = PER_W'(period_cycles >> PT_SHIFT);
            nxt_act_coef = coef_ff;
        end else if (step_done) begin
            nxt_pt = PT_W'(pt_ff + 1'b1);
            nxt_tick = step_ff;
            if (pt_ff == PT_LAST) begin
                nxt_step = PER_W'(period_cycles >> PT_SHIFT);
                nxt_tick = PER_W'(period_cycles >> PT_SHIFT);
                nxt_act_coef = coef_ff;
            end
            if (pt_ff == PT_LAST || pt_ff == PT_HALF_MASK) begin
                nxt_pol = ~pol_ff;
            end
        end else begin
            nxt_tick = PER_W'(tick_ff - 1'b1);
        end
    end

    always_comb begin
        fold = pt_ff & PT_HALF_MASK;
        if (fold > PT_PEAK) begin
            fold = PT_W'(PT_FOLD - fold);
        end
        unique case (fold)
            4'h1: cur_coef = act_coef_ff.p1;
            4'h2: cur_coef = act_coef_ff.p2;
            4'h3: cur_coef = act_coef_ff.p3;
            4'h4: cur_coef = COEF_FULL;
            default: cur_coef = COEF_NONE;
        endcase
        nxt_mag = '0;
        nxt_neg = 1'b0;
        if (st_ff == ST_DRIVE) begin
            if (!custom_shape_select) begin
                nxt_mag = direct_amplitude_value;
            end else if (fold == PT_PEAK) begin
                nxt_mag = direct_amplitude_value;
            end else begin
                nxt_mag = scale(direct_amplitude_value, cur_coef);
            end
            nxt_neg = (pt_ff >= PT_MID);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_ff <= ST_IDLE;
            fault_ff <= 1'b0;
            coef_ff <= '{p1: COEF1_RST, p2: COEF2_RST, p3: COEF3_RST};
            act_coef_ff <= '{p1: COEF1_RST, p2: COEF2_RST, p3: COEF3_RST};
            trim_ff <= '{uv_sel: UV_RST, ls_slew: SLEW_RST, hs_slew: SLEW_RST,
                         cap_trim: 2'h0, res_trim: 2'h0, narrow_band: 1'b0};
            step_ff <= PER_W'(PER_RST >> PT_SHIFT);
            tick_ff <= PER_W'(PER_RST >> PT_SHIFT);
            pt_ff <= PT_ZERO;
            mag_ff <= '0;
            neg_ff <= 1'b0;
            pol_ff <= 1'b0;
            act_ff <= 1'b0;
            loop_ff <= 1'b0;
        end else if (clk_en) begin
            st_ff <= nxt_st;
            fault_ff <= nxt_fault;
            coef_ff <= nxt_coef;
            act_coef_ff <= nxt_act_coef;
            trim_ff <= nxt_trim;
            step_ff <= nxt_step;
            tick_ff <= nxt_tick;
            pt_ff <= nxt_pt;
            mag_ff <= nxt_mag;
            neg_ff <= nxt_neg;
            pol_ff <= nxt_pol;
            act_ff <= nxt_act;
            loop_ff <= nxt_loop;
        end
    end

    assign drive_mag = mag_ff;
    assign drive_neg = neg_ff;
    assign drive_active = act_ff;
    assign current_loop_on = loop_ff;
    assign fault_flag = fault_ff;
    assign half_period_flag = pol_ff;
    assign point_index = pt_ff;
    assign coef_rd = coef_ff;
    assign trim_rd = trim_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    fault_stops_drive_a: assert property (clk_en && st_ff == ST_DRIVE && fault_detect
        |=> !drive_active && !current_loop_on) else $error("drive not stopped on fault");
    embedded_clear_a: assert property (clk_en && st_ff == ST_FAULT && embedded_mode
        && !fault_detect && !fault_clear |=> !fault_flag) else $error("fault kept");
    fault_sticky_a: assert property (clk_en && fault_detect |=> fault_flag)
        else $error("fault not set");
    half_toggle_a: assert property (clk_en && st_ff == ST_DRIVE && step_done
        && pt_ff == PT_HALF_MASK && !fault_detect && !play_stop
        |=> half_period_flag != $past(half_period_flag)) else $error("no toggle");
    // Flat mode drives the envelope at point zero, so only the custom shape is held to zero
    point_zero_a: assert property (clk_en && custom_shape_select && st_ff == ST_DRIVE
        && pt_ff == PT_ZERO |=> drive_mag == '0) else $error("point zero nonzero");
    point_peak_a: assert property (clk_en && st_ff == ST_DRIVE && pt_ff == PT_PEAK
        && !fault_detect && !play_stop |=> drive_mag == $past(direct_amplitude_value))
        else $error("peak not full scale");
    second_half_a: assert property (clk_en && st_ff == ST_DRIVE && pt_ff >= PT_MID
        |=> drive_neg) else $error("second half not inverted");
    idle_point_a: assert property (clk_en && st_ff == ST_IDLE |=> point_index == PT_ZERO)
        else $error("point not restarted");
    // Point five must reuse the third coefficient; coefficients only move at point fifteen
    mirror_a: assert property (clk_en && custom_shape_select && st_ff == ST_DRIVE
        && pt_ff == 4'h5 |=> drive_mag == scale($past(direct_amplitude_value), act_coef_ff.p3))
        else $error("no mirror");

    drive_cov: cover property (st_ff == ST_DRIVE && pt_ff == PT_LAST && step_done);
    fault_cov: cover property (st_ff == ST_FAULT && embedded_mode);
    coef_cov: cover property (coef_wr && st_ff == ST_DRIVE);
endmodule

/* File: test/actuator_model.sv */
// Actuator stand-in on the bridge output: records peak drive, shorts on command.
// Assumes the drive block's clock; a short is reported one cycle after it is seen.
`timescale 1ns/1ns
module actuator_model (
    input wire logic mclk,
    input wire logic drive_active,
    input wire logic [haptic_wave_pkg::AMP_W-1:0] drive_mag,
    input wire logic short_cmd,
    output logic fault_detect,
    output logic [haptic_wave_pkg::AMP_W-1:0] peak_mag
);
    import haptic_wave_pkg::*;
    initial fault_detect = 1'h0;
    initial peak_mag = '0;
    // a short only shows while current flows
    always @(posedge mclk) begin
        fault_detect <= short_cmd && drive_active;
        if (drive_active && drive_mag > peak_mag) begin
            peak_mag <= drive_mag;
        end
    end
endmodule

/* File: test/haptic_custom_wave_drive_bench.sv */
// Bench for the custom wave drive: shape, boundary updates, faults, trims.
// Assumes the package is compiled first and actuator_model sits at the output.
`timescale 1ns/1ns
module haptic_custom_wave_drive_bench;
    import haptic_wave_pkg::*;
    // Short period keeps runs brief: step 4, each point 4 cycles
    localparam logic [PER_W-1:0] PER = 20'h00040;
    // Longer period written mid-run: step 6
    localparam logic [PER_W-1:0] PER2 = 20'h00060;
    localparam trim_s TRIM_SET = '{uv_sel: 2'h3, ls_slew: 2'h0, hs_slew: 2'h0, cap_trim: 2'h2,
        res_trim: 2'h3, narrow_band: 1'h1};
    logic mclk, sys_rst, clk_en, custom_shape_select, embedded_mode, play_req, play_stop;
    logic fault_detect, fault_clear, coef_wr, trim_wr, drive_neg, drive_active, short_cmd;
    logic current_loop_on, fault_flag, half_period_flag;
    logic [AMP_W-1:0] direct_amplitude_value, drive_mag, peak_mag;
    logic [PT_W-1:0] point_index;
    logic [PER_W-1:0] period_cycles;
    coef_s coef_wdata, coef_rd;
    trim_s trim_wdata, trim_rd;
    logic [AMP_W-1:0] mag [16];
    logic neg [16];
    logic flg [17];
    int num_errors = 0, samples_checked = 0, cycles = 0, plen;

    haptic_custom_wave_drive u_dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
        .custom_shape_select(custom_shape_select), .embedded_mode(embedded_mode),
        .play_req(play_req), .play_stop(play_stop), .fault_detect(fault_detect),
        .fault_clear(fault_clear), .direct_amplitude_value(direct_amplitude_value),
        .period_cycles(period_cycles), .coef_wr(coef_wr), .coef_wdata(coef_wdata),
        .trim_wr(trim_wr),
        .trim_wdata(trim_wdata), .drive_mag(drive_mag), .drive_neg(drive_neg),
        .drive_active(drive_active), .current_loop_on(current_loop_on), .fault_flag(fault_flag),
        .half_period_flag(half_period_flag), .point_index(point_index), .coef_rd(coef_rd),
        .trim_rd(trim_rd));
    actuator_model u_act (.mclk(mclk), .drive_active(drive_active), .drive_mag(drive_mag),
        .short_cmd(short_cmd), .fault_detect(fault_detect), .peak_mag(peak_mag));

    task automatic end_of_test();
        $display("Summary: %0d checks, %0d mismatches", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_active(input logic v);
        for (int n = 0; n < 8 && drive_active !== v; n++) begin
            @(posedge mclk);
            #2;
        end
    endtask
    task automatic start_play();
        @(posedge mclk);
        play_req <= 1'h1;
        @(posedge mclk);
        play_req <= 1'h0;
        #2;
        wait_active(1'h1);
    endtask
    task automatic stop();
        @(posedge mclk);
        play_stop <= 1'h1;
        fault_clear <= 1'h1;
        @(posedge mclk);
        play_stop <= 1'h0;
        fault_clear <= 1'h0;
        #2;
        wait_active(1'h0);
    endtask
    // Samples one whole period from a point zero entry to the next
    task automatic grab();
        logic [PT_W-1:0] last;
        last = PT_ZERO;
        plen = 0;
        flg[0] = half_period_flag;
        while (plen < 400) begin
            @(posedge mclk);
            coef_wr <= 1'h0;
            #2;
            plen++;
            if (point_index !== last) begin
                last = point_index;
                if (last == PT_ZERO) begin
                    flg[16] = half_period_flag;
                    return;
                end
            end else begin
                // Magnitude and sign trail the point index by one cycle
                mag[last] = drive_mag;
                neg[last] = drive_neg;
            end
            flg[last] = half_period_flag;
        end
    endtask
    task automatic shape(input logic [AMP_W-1:0] amp, input logic [PER_W-1:0] per);
        chk("point0", mag[0], 32'h0);
        chk("point4", mag[4], amp);
        chk("period len", plen, 16 * (per >> 4));
        chk("flag at 8", flg[8], !flg[7]);
        chk("flag at 0", flg[16], !flg[15]);
        for (int k = 0; k < 16; k++) chk("flag hold", flg[k], flg[k & 8]);
        for (int k = 1; k < 4; k++) chk("mirror", mag[8 - k], mag[k]);
        for (int k = 0; k < 8; k++) chk("neg half", mag[k + 8], mag[k]);
        for (int k = 0; k < 16; k++) chk("polarity", neg[k], k >= 8);
    endtask

    task automatic t_regs();
        chk("coef rst", coef_rd, {COEF1_RST, COEF2_RST, COEF3_RST});
        chk("uv rst", trim_rd.uv_sel, UV_RST);
        chk("slew rst", {trim_rd.ls_slew, trim_rd.hs_slew}, {SLEW_RST, SLEW_RST});
        chk("idle", {drive_active, current_loop_on, fault_flag, drive_mag}, 32'h0);
        @(posedge mclk);
        // trims for a 20 ohm, 2 mH actuator, extreme uv and slew codes
        trim_wdata <= TRIM_SET;
        trim_wr <= 1'h1;
        clk_en <= 1'h0;
        repeat (2) @(posedge mclk);
        clk_en <= 1'h1;
        #2;
        chk("frozen", trim_rd.uv_sel, UV_RST);
        @(posedge mclk);
        trim_wr <= 1'h0;
        repeat (2) @(posedge mclk);
        #2;
        chk("trim set", trim_rd, TRIM_SET);
        $display("regs test done");
    endtask
    task automatic t_wave();
        // custom shape setup; this block has no resonance follow left to disable
        custom_shape_select <= 1'h1;
        direct_amplitude_value <= 8'hc8;
        start_play();
        chk("start", {current_loop_on, drive_mag}, 32'h100);
        grab();
        shape(8'hc8, PER);
        chk("rise", {mag[1] < mag[2], mag[2] < mag[3], mag[3] < mag[4]}, 32'h7);
        // new amplitude, coefficient and period just after a toggle
        direct_amplitude_value <= 8'h64;
        period_cycles <= PER2;
        coef_wdata <= {COEF_NONE, COEF2_RST, COEF3_RST};
        coef_wr <= 1'h1;
        grab();
        shape(8'h64, PER);
        chk("point1 old", mag[1] != 8'h0, 32'h1);
        grab();
        shape(8'h64, PER2);
        chk("point1 new", mag[1], 32'h0);
        chk("coef rd", coef_rd.p1, COEF_NONE);
        chk("peak", peak_mag, 32'hc8);
        stop();
        chk("stopped", drive_active, 32'h0);
        $display("wave test done");
    endtask
    task automatic t_fault(input logic emb);
        embedded_mode <= emb;
        // Flat magnitude in the plain run, custom shape in the embedded one
        custom_shape_select <= emb;
        start_play();
        @(posedge mclk);
        #2;
        chk("first point", drive_mag, emb ? 32'h0 : 32'h64);
        short_cmd <= 1'h1;
        @(posedge mclk);
        short_cmd <= 1'h0;
        #2;
        wait_active(1'h0);
        chk("loop off", {drive_active, current_loop_on}, 32'h0);
        repeat (3) @(posedge mclk);
        #2;
        chk("fault flag", fault_flag, !emb);
        start_play();
        chk("retry", drive_active, emb);
        stop();
        chk("idle again", drive_active, 32'h0);
        $display("fault test %0d done", emb);
    endtask

    initial begin
        mclk = 1'h0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        sys_rst = 1'h1;
        clk_en = 1'h1;
        {custom_shape_select, embedded_mode, play_req, play_stop} = '0;
        {fault_clear, coef_wr, trim_wr, short_cmd} = '0;
        direct_amplitude_value = '0;
        coef_wdata = '0;
        trim_wdata = '0;
        period_cycles = PER;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'h0;
        @(posedge mclk);
        #2;
        t_regs();
        t_wave();
        t_fault(1'h0);
        t_fault(1'h1);
        end_of_test();
    end
endmodule
